/* pam_port_a.sv */
// Summary of operation
// - Open-drain bit 1 drives low side only; bit 0 drives push-pull.
// - Open-drain register bits 7 to 4 ignore writes; they read as zero.
// - Open-drain applies only to port and serial outputs, not address or inputs.
// - Open-drain bits clear on power-on reset and hardware standby only.
// - Pin 3: address bit 19 on 11xx, else serial clock in or out.
// - Pin 3 follows direction when serial clock unused; mode 7 ignores address.
// - Pin 2: address bit 18 on 1011/11xx, else receive input or port.
// - Pin 1: address bit 17 on 101x/11xx, else transmit output or port.
// - Pin 0: address bit 16 unless 0xxx or 1000; else port pin.
// - Pull-up on only for inputs with direction 0 and pull-up bit 1.
// - Pull-up always off for address, port and serial outputs.
// - Pull-up off at power-on reset and hardware standby; kept otherwise.
// - Port pin is output with direction 1, input with direction 0.
// - Pin-state read gives data latch for direction 1, live pin for direction 0.
module pam_port_a
  import pam_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic hw_standby,
  // Chip configuration
  input wire logic [2:0] operating_mode,
  // Serial channel settings
  input wire logic clock_enable_high,
  input wire logic clock_enable_low,
  input wire logic clocked_mode,
  input wire logic receive_enable_bit,
  input wire logic transmit_enable_bit,
  // Serial channel data
  input wire logic serial_clock_out_data,
  input wire logic serial_transmit_data,
  output logic serial_clock_in_data,
  output logic serial_receive_data,
  // Upper address bits 19 to 16
  input wire logic [3:0] address_upper,
  // Pads
  input wire logic [3:0] pad_in,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe,
  output logic [3:0] pullup_en,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < PAM_ADDR_W_MIN) begin : g_bad_addr_w
    $error("ADDR_W too small for the register map");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0] direction_q;
  logic [3:0] direction_d;
  logic [3:0] output_data_q;
  logic [3:0] output_data_d;
  logic [3:0] pullup_select_q;
  logic [3:0] pullup_select_d;
  logic [3:0] open_drain_select_q;
  logic [3:0] open_drain_select_d;
  logic [3:0] address_enable_field_q;
  logic [3:0] address_enable_field_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] readdata_q;
  logic [31:0] readdata_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic request;
  logic commit;
  logic wr_commit;
  logic low_lane;
  logic [4:0] reg_ofs;
  logic [3:0] wr_field;
  logic [3:0] pin_state;

  assign request = read | write;
  assign reg_ofs = {address[4:2], 2'b00};
  assign low_lane = byteenable[0];
  assign wr_field = writedata[PAM_FIELD_MSB:PAM_FIELD_LSB];

  // One wait cycle; the read word is caught in it so that it stands
  // at the edge where waitrequest is sampled low.
  assign commit = request & ack_q & clock_enable;
  assign wr_commit = commit & write & low_lane;
  assign waitrequest = request & ~commit;

  always_comb begin
    ack_d = ack_q;
    if (ack_q) begin
      ack_d = 1'b0;
    end else if (request) begin
      ack_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pin-state view
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < PAM_PINS; i++) begin
      pin_state[i] = direction_q[i] ? output_data_q[i] : pad_in[i];
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    readdata_d = readdata_q;
    if (read && !ack_q) begin
      readdata_d = PAM_READ_ZERO;
      case (reg_ofs)
        PAM_OFS_DIRECTION: begin
          // Write-only register reads as zero
          readdata_d = PAM_READ_ZERO;
        end
        PAM_OFS_OUTPUT_DATA: begin
          readdata_d[PAM_FIELD_MSB:PAM_FIELD_LSB] = output_data_q;
        end
        PAM_OFS_PIN_STATE: begin
          readdata_d[PAM_FIELD_MSB:PAM_FIELD_LSB] = pin_state;
        end
        PAM_OFS_PULLUP_SELECT: begin
          readdata_d[PAM_FIELD_MSB:PAM_FIELD_LSB] = pullup_select_q;
        end
        PAM_OFS_OPEN_DRAIN_SELECT: begin
          // Upper bits are not stored; they read as zero
          readdata_d[PAM_FIELD_MSB:PAM_FIELD_LSB] = open_drain_select_q;
        end
        PAM_OFS_PIN_FUNCTION_CONTROL: begin
          readdata_d[PAM_FIELD_MSB:PAM_FIELD_LSB] = address_enable_field_q;
        end
        default: begin
          readdata_d = PAM_READ_ZERO;
        end
      endcase
    end
  end

  assign readdata = readdata_q;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  // Hardware standby clears like power-on reset; manual reset and
  // software standby never reach this block, so state is kept.
  always_comb begin
    direction_d = direction_q;
    output_data_d = output_data_q;
    pullup_select_d = pullup_select_q;
    open_drain_select_d = open_drain_select_q;
    address_enable_field_d = address_enable_field_q;
    if (hw_standby) begin
      direction_d = PAM_DIRECTION_RST;
      output_data_d = PAM_OUTPUT_DATA_RST;
      pullup_select_d = PAM_PULLUP_SELECT_RST;
      open_drain_select_d = PAM_OPEN_DRAIN_RST;
      address_enable_field_d = PAM_AE_RST;
    end else if (wr_commit) begin
      case (reg_ofs)
        PAM_OFS_DIRECTION: begin
          direction_d = wr_field;
        end
        PAM_OFS_OUTPUT_DATA: begin
          output_data_d = wr_field;
        end
        PAM_OFS_PULLUP_SELECT: begin
          pullup_select_d = wr_field;
        end
        PAM_OFS_OPEN_DRAIN_SELECT: begin
          // Bits 7 to 4 are dropped here
          open_drain_select_d = wr_field;
        end
        PAM_OFS_PIN_FUNCTION_CONTROL: begin
          address_enable_field_d = wr_field;
        end
        default: begin
          direction_d = direction_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      direction_q <= PAM_DIRECTION_RST;
      output_data_q <= PAM_OUTPUT_DATA_RST;
      pullup_select_q <= PAM_PULLUP_SELECT_RST;
      open_drain_select_q <= PAM_OPEN_DRAIN_RST;
      address_enable_field_q <= PAM_AE_RST;
      ack_q <= 1'b0;
      readdata_q <= PAM_READ_ZERO;
    end else if (clock_enable) begin
      direction_q <= direction_d;
      output_data_q <= output_data_d;
      pullup_select_q <= pullup_select_d;
      open_drain_select_q <= open_drain_select_d;
      address_enable_field_q <= address_enable_field_d;
      ack_q <= ack_d;
      readdata_q <= readdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin function selection
  // ----------------------------------------------------------------
  logic addr_mode;
  logic [3:0] addr_match;
  logic [3:0] serial_in_sel;
  logic [3:0] serial_out_sel;
  logic [3:0] serial_data;
  pam_use_e pin_use [PAM_PINS];

  // Mode 7 and modes 0 to 3 ignore the address-enable field
  assign addr_mode = (operating_mode >= PAM_MODE_EXT_LO) &&
                     (operating_mode <= PAM_MODE_EXT_HI);

  always_comb begin
    for (int i = 0; i < PAM_PINS; i++) begin
      addr_match[i] = pam_addr_match(address_enable_field_q, i);
    end
  end

  always_comb begin
    serial_in_sel = 4'h0;
    serial_out_sel = 4'h0;
    serial_data = 4'h0;
    // Pin 3: external clock wins over internal clock output
    serial_in_sel[3] = clock_enable_high;
    serial_out_sel[3] = ~clock_enable_high & (clocked_mode | clock_enable_low);
    serial_data[3] = serial_clock_out_data;
    serial_in_sel[2] = receive_enable_bit;
    serial_out_sel[1] = transmit_enable_bit;
    serial_data[1] = serial_transmit_data;
    // Pin 0 has no serial function
    serial_in_sel[0] = 1'b0;
    serial_out_sel[0] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Per-pin select and drive
  // ----------------------------------------------------------------
  for (genvar p = 0; p < PAM_PINS; p++) begin : g_pin
    pam_pin_select u_select (
      .addr_mode(addr_mode),
      .addr_match(addr_match[p]),
      .serial_in_sel(serial_in_sel[p]),
      .serial_out_sel(serial_out_sel[p]),
      .direction_bit(direction_q[p]),
      .pin_use(pin_use[p])
    );

    pam_pin_drive u_drive (
      .pin_use(pin_use[p]),
      .direction_bit(direction_q[p]),
      .open_drain_bit(open_drain_select_q[p]),
      .pullup_bit(pullup_select_q[p]),
      .standby(hw_standby),
      .port_data(output_data_q[p]),
      .serial_data(serial_data[p]),
      .addr_data(address_upper[p]),
      .pad_out(pad_out[p]),
      .pad_oe(pad_oe[p]),
      .pullup_en(pullup_en[p])
    );
  end

  // ----------------------------------------------------------------
  // Serial inputs back to the channel
  // ----------------------------------------------------------------
  // Gated so the channel sees a quiet zero while the pin serves
  // another use; it is not resynchronised here.
  always_comb begin
    serial_clock_in_data = (pin_use[3] == PAM_SERIAL_IN) ? pad_in[3] : 1'b0;
    serial_receive_data = (pin_use[2] == PAM_SERIAL_IN) ? pad_in[2] : 1'b0;
  end

endmodule

/* pam_pkg.sv */
package pam_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int PAM_PINS = 4;
  localparam int PAM_AE_W = 4;
  localparam int PAM_MODE_W = 3;
  localparam int PAM_ADDR_W_MIN = 5;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] PAM_OFS_DIRECTION = 5'h00;
  localparam logic [4:0] PAM_OFS_OUTPUT_DATA = 5'h04;
  localparam logic [4:0] PAM_OFS_PIN_STATE = 5'h08;
  localparam logic [4:0] PAM_OFS_PULLUP_SELECT = 5'h0c;
  localparam logic [4:0] PAM_OFS_OPEN_DRAIN_SELECT = 5'h10;
  localparam logic [4:0] PAM_OFS_PIN_FUNCTION_CONTROL = 5'h14;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int PAM_FIELD_LSB = 0;
  localparam int PAM_FIELD_MSB = 3;
  localparam logic [3:0] PAM_DIRECTION_RST = 4'h0;
  localparam logic [3:0] PAM_OUTPUT_DATA_RST = 4'h0;
  localparam logic [3:0] PAM_PULLUP_SELECT_RST = 4'h0;
  localparam logic [3:0] PAM_OPEN_DRAIN_RST = 4'h0;
  localparam logic [3:0] PAM_AE_RST = 4'h0;
  localparam logic [31:0] PAM_READ_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  localparam logic [2:0] PAM_MODE_EXT_LO = 3'h4;
  localparam logic [2:0] PAM_MODE_EXT_HI = 3'h6;

  // ----------------------------------------------------------------
  // Pin uses
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PAM_PORT_IN = 3'b000,
    PAM_PORT_OUT = 3'b001,
    PAM_SERIAL_IN = 3'b010,
    PAM_SERIAL_OUT = 3'b011,
    PAM_ADDR_OUT = 3'b100
  } pam_use_e;

  // Address-enable decode, per pin
  function automatic logic pam_addr_match(input logic [3:0] ae, input int pin);
    logic m;
    m = 1'b0;
    case (pin)
      3: m = ae[3] & ae[2];
      2: m = ae[3] & (ae[2] | (ae[1] & ae[0]));
      1: m = ae[3] & (ae[2] | ae[1]);
      default: m = ae[3] & (ae[2:0] != 3'h0);
    endcase
    return m;
  endfunction

endpackage

/* pam_pin_select.sv */
module pam_pin_select
  import pam_pkg::*;
(
  // Selection inputs
  input wire logic addr_mode,
  input wire logic addr_match,
  input wire logic serial_in_sel,
  input wire logic serial_out_sel,
  input wire logic direction_bit,
  // Result
  output pam_use_e pin_use
);

  // ----------------------------------------------------------------
  // Priority: address, then serial channel, then direction
  // ----------------------------------------------------------------
  always_comb begin
    if (addr_mode && addr_match) begin
      pin_use = PAM_ADDR_OUT;
    end else if (serial_in_sel) begin
      pin_use = PAM_SERIAL_IN;
    end else if (serial_out_sel) begin
      pin_use = PAM_SERIAL_OUT;
    end else if (direction_bit) begin
      pin_use = PAM_PORT_OUT;
    end else begin
      pin_use = PAM_PORT_IN;
    end
  end

endmodule

/* pam_pin_drive.sv */
module pam_pin_drive
  import pam_pkg::*;
(
  // Pin setting
  input pam_use_e pin_use,
  input wire logic direction_bit,
  input wire logic open_drain_bit,
  input wire logic pullup_bit,
  input wire logic standby,
  // Output sources
  input wire logic port_data,
  input wire logic serial_data,
  input wire logic addr_data,
  // Pad
  output logic pad_out,
  output logic pad_oe,
  output logic pullup_en
);

  logic value;

  // ----------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------
  always_comb begin
    value = 1'b0;
    pad_out = 1'b0;
    pad_oe = 1'b0;
    unique case (pin_use)
      PAM_ADDR_OUT: begin
        // Address lines always push-pull
        pad_out = addr_data;
        pad_oe = 1'b1;
      end
      PAM_PORT_OUT, PAM_SERIAL_OUT: begin
        value = (pin_use == PAM_PORT_OUT) ? port_data : serial_data;
        if (open_drain_bit) begin
          // Low side only; a high is left to the board pull-up
          pad_out = 1'b0;
          pad_oe = ~value;
        end else begin
          pad_out = value;
          pad_oe = 1'b1;
        end
      end
      PAM_PORT_IN, PAM_SERIAL_IN: begin
        pad_out = 1'b0;
        pad_oe = 1'b0;
      end
      default: begin
        pad_out = 1'b0;
        pad_oe = 1'b0;
      end
    endcase
    if (standby) begin
      pad_oe = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Input pull-up
  // ----------------------------------------------------------------
  always_comb begin
    pullup_en = 1'b0;
    if ((pin_use == PAM_PORT_IN || pin_use == PAM_SERIAL_IN) && !direction_bit
        && pullup_bit && !standby) begin
      pullup_en = 1'b1;
    end
  end

endmodule

/* pam_port_a_checker.sv */
module pam_port_a_checker
  import pam_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic hw_standby,
  // Settings
  input wire logic [2:0] operating_mode,
  input wire logic clock_enable_high,
  input wire logic receive_enable_bit,
  input wire logic transmit_enable_bit,
  // Serial data
  input wire logic serial_transmit_data,
  input wire logic serial_clock_in_data,
  input wire logic serial_receive_data,
  // Pads
  input wire logic [3:0] address_upper,
  input wire logic [3:0] pad_in,
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe,
  input wire logic [3:0] pullup_en,
  // Bus
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Shadow of the registers, rebuilt from committed writes
  // ----------------------------------------------------------------
  logic [3:0] od_q, od_d, dir_q, dir_d, ae_q, ae_d;
  logic ext_mode, port_mode, commit;
  // Only lane 0 carries register bits; the rest is ignored on write
  logic [3:0] writedata_lo;
  assign writedata_lo = writedata[3:0];
  assign ext_mode = operating_mode >= PAM_MODE_EXT_LO && operating_mode <= PAM_MODE_EXT_HI;
  assign port_mode = !ext_mode && !hw_standby;
  assign commit = write && !waitrequest && byteenable[0];
  always_comb begin
    od_d = od_q;
    dir_d = dir_q;
    ae_d = ae_q;
    if (hw_standby) begin
      od_d = 4'h0;
      dir_d = 4'h0;
      ae_d = 4'h0;
    end else if (commit) begin
      if (address[4:2] == PAM_OFS_OPEN_DRAIN_SELECT[4:2]) od_d = writedata_lo;
      if (address[4:2] == PAM_OFS_DIRECTION[4:2]) dir_d = writedata_lo;
      if (address[4:2] == PAM_OFS_PIN_FUNCTION_CONTROL[4:2]) ae_d = writedata_lo;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      od_q <= 4'h0;
      dir_q <= 4'h0;
      ae_q <= 4'h0;
    end else if (clock_enable) begin
      od_q <= od_d;
      dir_q <= dir_d;
      ae_q <= ae_d;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_wait_once: assert property ($rose(read || write) && clock_enable |-> waitrequest ##1
    !waitrequest) else $error("bus answer not after exactly one wait cycle");
  a_od_readback: assert property (read && !waitrequest && address[4:2] == 3'h4 |->
    readdata[3:0] == od_q) else $error("open drain readback differs");
  a_stby_off: assert property (hw_standby |-> pad_oe == 4'h0 && pullup_en == 4'h0)
    else $error("pins not released in standby");
  a_pullup_inputs: assert property ((pullup_en & pad_oe) == 4'h0)
    else $error("pull-up on a driven pin");
  a_addr_pin3: assert property (ext_mode && !hw_standby && ae_q[3] && ae_q[2] |->
    pad_oe[3] && pad_out[3] == address_upper[3]) else $error("pin 3 not address");
  a_addr_pin0: assert property (ext_mode && !hw_standby && ae_q[3] && ae_q[2:0] != 3'h0
    |-> pad_oe[0] && pad_out[0] == address_upper[0]) else $error("pin 0 not address");
  a_port_drive: assert property (port_mode |-> (dir_q[0] ? (od_q[0] ? !pad_out[0] :
    pad_oe[0]) : !pad_oe[0])) else $error("pin 0 drive mode wrong");
  a_rx_in: assert property (port_mode && receive_enable_bit |-> !pad_oe[2] &&
    serial_receive_data == pad_in[2]) else $error("receive pin not input");
  a_tx_out: assert property (port_mode && transmit_enable_bit && !od_q[1] |-> pad_oe[1]
    && pad_out[1] == serial_transmit_data) else $error("transmit pin not driven");
  a_ck_in: assert property (port_mode && clock_enable_high |-> !pad_oe[3] &&
    serial_clock_in_data == pad_in[3]) else $error("clock pin not input");
endmodule

/* pam_pads_model.sv */
module pam_pads_model (
  // Clock
  input wire logic clock,
  // Pad drive from the port
  input wire logic [3:0] pad_out,
  input wire logic [3:0] pad_oe,
  input wire logic [3:0] pullup_en,
  // Board drive
  input wire logic [3:0] ext_drive,
  input wire logic [3:0] ext_val,
  // Level seen by the port
  output logic [3:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // A floating line toggles every cycle so a stale value cannot pass
  logic [3:0] float_q = 4'h5;
  always @(posedge clock) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_drive[i] ? ext_val[i] :
        pullup_en[i] ? 1'b1 : float_q[i];
    end
  end
endmodule

/* pam_port_a_tb.sv */
module pam_port_a_tb;
  import pam_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, clock_enable = 1, hw_standby = 0;
  logic [2:0] operating_mode = 3'h7;
  logic clock_enable_high = 0, clock_enable_low = 0, clocked_mode = 0;
  logic receive_enable_bit = 0, transmit_enable_bit = 0;
  logic serial_clock_out_data = 0, serial_transmit_data = 0;
  logic serial_clock_in_data, serial_receive_data, waitrequest, read = 0, write = 0;
  logic [3:0] address_upper = 4'ha, ext_drive = 0, ext_val = 0, byteenable = 4'hf;
  logic [3:0] pad_in, pad_out, pad_oe, pullup_en, m;
  logic [4:0] address = 0;
  logic [31:0] writedata = 0, readdata, rd;
  int n_mismatch = 0, tests_run = 0;
  always #25 clock = ~clock;
  pam_port_a #(.ADDR_W(5)) uut (.clock, .rst, .clock_enable, .hw_standby, .operating_mode,
    .clock_enable_high, .clock_enable_low, .clocked_mode, .receive_enable_bit,
    .transmit_enable_bit, .serial_clock_out_data, .serial_transmit_data,
    .serial_clock_in_data, .serial_receive_data, .address_upper, .pad_in, .pad_out,
    .pad_oe, .pullup_en, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest);
  pam_pads_model pads (.clock, .pad_out, .pad_oe, .pullup_en, .ext_drive, .ext_val, .pad_in);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic summarize;
    if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then lets one edge pass
  task automatic bus(input logic we, input logic [4:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    address <= a;
    write <= we;
    read <= !we;
    writedata <= {24'h0, wd};
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
    if (n >= 20) begin
      n_mismatch++;
      summarize();
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] wd);
    bus(1'b1, a, wd);
  endtask
  // Reserved upper bits read as zero; only the low nibble is judged
  task automatic rdc(input logic [4:0] a, input logic [3:0] e);
    bus(1'b0, a, 8'h0);
    chk("readdata", 32'(e), 32'(rd[3:0]));
  endtask
  task automatic pins(input logic [3:0] oe, pu, msk, out);
    @(negedge clock);
    chk("pad_oe", 32'(oe), 32'(pad_oe));
    chk("pullup_en", 32'(pu), 32'(pullup_en));
    chk("pad_out", 32'(out), 32'(pad_out & msk));
    @(posedge clock);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    pins(4'h0, 4'h0, 4'h0, 4'h0);
    rdc(PAM_OFS_OPEN_DRAIN_SELECT, 4'h0);
    rdc(PAM_OFS_PULLUP_SELECT, 4'h0);
    rdc(5'h1c, 4'h0);
  endtask
  task automatic t_open_drain;
    wr(PAM_OFS_OUTPUT_DATA, 8'h05);
    wr(PAM_OFS_DIRECTION, 8'h0f);
    pins(4'hf, 4'h0, 4'hf, 4'h5);
    wr(PAM_OFS_OPEN_DRAIN_SELECT, 8'hff);
    pins(4'ha, 4'h0, 4'hf, 4'h0);
    rdc(PAM_OFS_OPEN_DRAIN_SELECT, 4'hf);
    rdc(PAM_OFS_PIN_STATE, 4'h5);
  endtask
  task automatic t_pullup;
    wr(PAM_OFS_OPEN_DRAIN_SELECT, 8'h00);
    wr(PAM_OFS_DIRECTION, 8'h03);
    wr(PAM_OFS_PULLUP_SELECT, 8'h0f);
    pins(4'h3, 4'hc, 4'h3, 4'h1);
    rdc(PAM_OFS_PIN_STATE, 4'hd);
    ext_drive <= 4'h4;
    rdc(PAM_OFS_PIN_STATE, 4'h9);
    wr(PAM_OFS_OPEN_DRAIN_SELECT, 8'h0f);
  endtask
  task automatic t_standby;
    hw_standby <= 1'b1;
    pins(4'h0, 4'h0, 4'h0, 4'h0);
    hw_standby <= 1'b0;
    rdc(PAM_OFS_OPEN_DRAIN_SELECT, 4'h0);
    rdc(PAM_OFS_PULLUP_SELECT, 4'h0);
  endtask
  // Serial enables stay on so address output must win over them
  task automatic t_addr;
    operating_mode <= 3'h5;
    clock_enable_high <= 1'b1;
    receive_enable_bit <= 1'b1;
    transmit_enable_bit <= 1'b1;
    serial_transmit_data <= 1'b1;
    wr(PAM_OFS_PULLUP_SELECT, 8'h0f);
    wr(PAM_OFS_OPEN_DRAIN_SELECT, 8'h0f);
    for (int ae = 0; ae < 16; ae++) begin
      m[3] = ae[3:2] == 2'b11;
      m[2] = ae[3:0] == 4'hb || ae[3:2] == 2'b11;
      m[1] = ae[3:1] == 3'b101 || ae[3:2] == 2'b11;
      m[0] = ae[3] && ae[3:0] != 4'h8;
      wr(PAM_OFS_PIN_FUNCTION_CONTROL, 8'(ae));
      pins(m, ~m & 4'hd, m, address_upper & m);
    end
    operating_mode <= 3'h7;
    pins(4'h0, 4'hd, 4'h0, 4'h0);
  endtask
  task automatic t_serial;
    wr(PAM_OFS_OPEN_DRAIN_SELECT, 8'h00);
    wr(PAM_OFS_DIRECTION, 8'h0f);
    wr(PAM_OFS_OUTPUT_DATA, 8'h0f);
    transmit_enable_bit <= 1'b0;
    ext_drive <= 4'hc;
    ext_val <= 4'h8;
    @(negedge clock);
    chk("serial_clock_in_data", 32'h1, 32'(serial_clock_in_data));
    chk("serial_receive_data", 32'h0, 32'(serial_receive_data));
    pins(4'h3, 4'h0, 4'h3, 4'h3);
    clock_enable_high <= 1'b0;
    clocked_mode <= 1'b1;
    transmit_enable_bit <= 1'b1;
    serial_transmit_data <= 1'b0;
    // Clock output high so that pin 3 shows the channel's value, not a default
    serial_clock_out_data <= 1'b1;
    pins(4'hb, 4'h0, 4'hb, 4'h9);
    serial_transmit_data <= 1'b1;
    wr(PAM_OFS_OPEN_DRAIN_SELECT, 8'h02);
    pins(4'h9, 4'h0, 4'h9, 4'h9);
    clocked_mode <= 1'b0;
    clock_enable_low <= 1'b1;
    pins(4'h9, 4'h0, 4'h9, 4'h9);
    // Clock output low while the port latch is high tells the two uses apart
    clock_enable_low <= 1'b0;
    serial_clock_out_data <= 1'b0;
    pins(4'h9, 4'h0, 4'h9, 4'h9);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_open_drain();
    t_pullup();
    t_standby();
    t_addr();
    t_serial();
    summarize();
  end
endmodule
bind pam_port_a pam_port_a_checker #(.ADDR_W(ADDR_W)) chk_i (.clock, .rst, .clock_enable,
  .hw_standby, .operating_mode, .clock_enable_high, .receive_enable_bit, .transmit_enable_bit,
  .serial_transmit_data, .serial_clock_in_data, .serial_receive_data, .address_upper, .pad_in,
  .pad_out, .pad_oe, .pullup_en, .address, .read, .write, .writedata, .byteenable, .readdata,
  .waitrequest);
